// File: logic/itfr_pkg.sv
// Functional notes
// RL1 - one selection code per input terminal
// RL2 - code 2: high speed, or remote accelerate
// RL3 - remote mode turns speeds into clear/decel/accel
// RL4 - code 6: restart after supply loss
// RL5 - code 7: external thermal trip input
// RL6 - thermal trip active on open contact
// RL7 - code 8: fourth speed bit, 15 speeds
// RL8 - code 10: converter run permit
// RL9 - code 12: panel mode interlock
// RL10 - code 13: dc brake start
// RL11 - code 14: pid enable input
// RL12 - code 60: forward run, forward terminal only
// RL13 - code 61: reverse run, reverse terminal only
// RL14 - code 63: thermistor, current-select terminal only
// RL15 - code 67: command source switch
// RL16 - codes 70/71: dc feed permit and cancel
// RL17 - code 72: pid integral clear
// RL18 - duplicate assignments are ORed
// RL19 - priority jog, then multi-speed, then pid
// RL20 - output shutoff stands in for unassigned functions; code: run permit always, panel interlock only in OPMODE_PANEL
// RL21 - preset and remote speeds share terminals
// RL22 - code 24: output shutoff, also bypass
// RL23 - code 9999 drives nothing
package itfr_pkg;
    localparam int NUM_TERM = 12;
    localparam int CODE_W = 14;
    localparam int NUM_FN = 29;
    localparam int FN_W = 5;
    localparam int MODE_W = 8;
    localparam int ADDR_W = 8;
    localparam int SPD_W = 4;
    // terminal positions with restricted codes
    localparam int TERM_FWD = 0;
    localparam int TERM_REV = 1;
    localparam int TERM_CSEL = 6;
    localparam logic [CODE_W-1:0] CODE_THERM = 14'h0007;
    localparam logic [CODE_W-1:0] CODE_FWD = 14'h003C;
    localparam logic [CODE_W-1:0] CODE_REV = 14'h003D;
    localparam logic [CODE_W-1:0] CODE_PTC = 14'h003F;
    localparam logic [CODE_W-1:0] CODE_SHUT = 14'h0018;
    localparam logic [CODE_W-1:0] CODE_HIGH = 14'h0002;
    localparam logic [CODE_W-1:0] CODE_NONE = 14'h270F;
    // function slots
    localparam int FN_LOW = 0, FN_MID = 1, FN_HIGH = 2, FN_ALT = 3, FN_CSEL = 4, FN_JOG = 5;
    localparam int FN_RESTART = 6, FN_THERM = 7, FN_FOURTH = 8, FN_CONV = 9, FN_CPF = 10;
    localparam int FN_PANEL = 11, FN_DCBRK = 12, FN_PID = 13, FN_PUEXT = 14, FN_SHUT = 15;
    localparam int FN_HOLD = 16, FN_TRAV = 17, FN_FWD = 18, FN_REV = 19, FN_RESET = 20;
    localparam int FN_PTC = 21, FN_PIDDIR = 22, FN_PUNET = 23, FN_EXTNET = 24, FN_CMDSW = 25;
    localparam int FN_DCPERM = 26, FN_DCCAN = 27, FN_PIDCLR = 28;
    localparam logic [CODE_W-1:0] SEL_RST [NUM_TERM] = '{14'h003C, 14'h003D, 14'h0000, 14'h0001,
        14'h0002, 14'h0003, 14'h0004, 14'h0005, 14'h0006, 14'h0018, 14'h0019, 14'h003E};
    localparam logic [MODE_W-1:0] OPMODE_PANEL = 8'h07;
    localparam logic [ADDR_W-1:0] OFF_SEL0 = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_MODE = 8'h30;
    localparam logic [ADDR_W-1:0] OFF_OPMODE = 8'h34;
    localparam logic [ADDR_W-1:0] OFF_TERM = 8'h38;
    localparam logic [ADDR_W-1:0] OFF_FUNC = 8'h3C;
    localparam logic [ADDR_W-1:0] OFF_SPEED = 8'h40;

    typedef enum logic [3:0] {
        SRC_NONE = 4'b0001,
        SRC_JOG = 4'b0010,
        SRC_MULTI = 4'b0100,
        SRC_PID = 4'b1000
    } itfr_src_t;

    // {known, slot}; unknown codes and 9999 map to nothing
    function automatic logic [FN_W:0] itfr_decode(input logic [CODE_W-1:0] c);
        logic [FN_W:0] r;
        r = '0;
        case (c)
            14'h0000, 14'h0001, 14'h0002, 14'h0003, 14'h0004, 14'h0005, 14'h0006, 14'h0007,
            14'h0008: r = {1'b1, c[FN_W-1:0]};
            14'h000A: r = {1'b1, 5'(FN_CONV)};
            14'h000B: r = {1'b1, 5'(FN_CPF)};
            14'h000C: r = {1'b1, 5'(FN_PANEL)};
            14'h000D: r = {1'b1, 5'(FN_DCBRK)};
            14'h000E: r = {1'b1, 5'(FN_PID)};
            14'h0010: r = {1'b1, 5'(FN_PUEXT)};
            14'h0018: r = {1'b1, 5'(FN_SHUT)};
            14'h0019: r = {1'b1, 5'(FN_HOLD)};
            14'h0025: r = {1'b1, 5'(FN_TRAV)};
            14'h003C: r = {1'b1, 5'(FN_FWD)};
            14'h003D: r = {1'b1, 5'(FN_REV)};
            14'h003E: r = {1'b1, 5'(FN_RESET)};
            14'h003F: r = {1'b1, 5'(FN_PTC)};
            14'h0040: r = {1'b1, 5'(FN_PIDDIR)};
            14'h0041: r = {1'b1, 5'(FN_PUNET)};
            14'h0042: r = {1'b1, 5'(FN_EXTNET)};
            14'h0043: r = {1'b1, 5'(FN_CMDSW)};
            14'h0046: r = {1'b1, 5'(FN_DCPERM)};
            14'h0047: r = {1'b1, 5'(FN_DCCAN)};
            14'h0048: r = {1'b1, 5'(FN_PIDCLR)};
            default: r = '0;
        endcase
        return r;
    endfunction
endpackage

// File: logic/itfr_speed_prio.sv
`timescale 1ns/1ps
module itfr_speed_prio
    import itfr_pkg::*;
(
    input wire logic jog, // jog request
    input wire logic multi, // any preset speed bit
    input wire logic pid, // pid control active
    output itfr_src_t src // winning speed source
);
    always_comb begin
        if (jog) begin
            src = SRC_JOG; // [RL19]
        end else if (multi) begin
            src = SRC_MULTI; // [RL19]
        end else if (pid) begin
            src = SRC_PID; // [RL19]
        end else begin
            src = SRC_NONE;
        end
    end
endmodule

// File: logic/itfr_router.sv
// Design decisions made here: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module itfr_router
    import itfr_pkg::*;
(
    input wire logic core_clk, // 10 MHz clock
    input wire logic reset_n, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [ADDR_W-1:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error
    input wire logic [NUM_TERM-1:0] term_in, // contacts, 1 = closed
    output logic low_speed_select, // preset speed bit 0
    output logic mid_speed_select, // preset speed bit 1
    output logic high_speed_select, // preset speed bit 2
    output logic fourth_speed_bit, // preset speed bit 3
    output logic remote_clear, // remote setting clear
    output logic remote_decel, // remote setting down
    output logic remote_accel, // remote setting up
    output logic alternate_parameter_set, // second parameter set
    output logic current_input_select, // current input select
    output logic jog_select, // jog operation
    output logic power_loss_auto_restart, // restart after supply loss
    output logic external_thermal_trip, // overload relay tripped
    output logic converter_run_permit, // converter allows run
    output logic converter_power_fail, // converter supply loss
    output logic panel_mode_interlock, // keypad interlock
    output logic dc_brake_start, // dc injection brake
    output logic pid_enable_input, // pid control valid
    output logic panel_ext_switch, // keypad/external switch
    output logic output_shutoff, // output stop and bypass
    output logic start_self_hold, // start self-holding
    output logic traverse_select, // traverse function
    output logic forward_run_cmd, // forward run
    output logic reverse_run_cmd, // reverse run
    output logic drive_reset, // drive reset
    output logic thermistor_input, // thermistor input
    output logic pid_direction_switch, // pid action reverse
    output logic panel_net_switch, // keypad/network switch
    output logic ext_net_switch, // external/network switch
    output logic command_source_switch, // alternate command source
    output logic dc_feed_permit, // dc feed operation allowed
    output logic dc_feed_cancel, // dc feed cancel
    output logic pid_integral_clear, // pid integral reset
    output logic [3:0] speed_source, // one-hot winning source
    output logic [SPD_W-1:0] speed_index // preset speed number
);
    logic rst_meta;
    logic rst_n;
    logic [CODE_W-1:0] sel_q [NUM_TERM];
    logic [CODE_W-1:0] next_sel [NUM_TERM];
    logic [MODE_W-1:0] remote_mode;
    logic [MODE_W-1:0] next_remote_mode;
    logic [MODE_W-1:0] op_mode;
    logic [MODE_W-1:0] next_op_mode;
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    logic [NUM_FN-1:0] fn_hit [NUM_TERM];
    logic [NUM_FN-1:0] fn_or;
    logic [NUM_FN-1:0] fn_asg;
    logic [NUM_FN-1:0] fn_q;
    logic [NUM_FN-1:0] next_fn;
    logic remote_on;
    logic multi_req;
    itfr_src_t src_w;
    logic [3:0] next_src;
    logic [SPD_W-1:0] next_index;
    logic bus_wr;
    logic setup;
    logic [3:0] sel_idx;
    logic sel_hit;

    // release of reset passes two flops; assertion stays asynchronous
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // a code is taken only where the terminal may carry it
    function automatic logic code_ok(input int t, input logic [CODE_W-1:0] c);
        logic ok;
        logic [FN_W:0] d;
        d = itfr_decode(c);
        ok = d[FN_W] || (c == CODE_NONE);
        if (c == CODE_FWD && t != TERM_FWD) begin
            ok = 1'b0; // [RL12]
        end
        if (c == CODE_REV && t != TERM_REV) begin
            ok = 1'b0; // [RL13]
        end
        if (c == CODE_PTC && t != TERM_CSEL) begin
            ok = 1'b0; // [RL14]
        end
        return ok;
    endfunction

    assign setup = psel && !penable;
    assign bus_wr = psel && penable && pready && pwrite;
    assign sel_idx = paddr[5:2];
    assign sel_hit = (paddr[1:0] == 2'b00) && (paddr < OFF_MODE);

    // registers: one selection code per terminal plus two mode words
    always_comb begin
        next_sel = sel_q;
        next_remote_mode = remote_mode;
        next_op_mode = op_mode;
        if (bus_wr && !pslverr) begin
            if (sel_hit) begin
                next_sel[sel_idx] = pwdata[CODE_W-1:0]; // [RL1]
            end else if (paddr == OFF_MODE) begin
                next_remote_mode = pwdata[MODE_W-1:0];
            end else if (paddr == OFF_OPMODE) begin
                next_op_mode = pwdata[MODE_W-1:0];
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sel_q <= SEL_RST;
            remote_mode <= '0;
            op_mode <= '0;
        end else begin
            sel_q <= next_sel;
            remote_mode <= next_remote_mode;
            op_mode <= next_op_mode;
        end
    end

    // answer is prepared in setup so every bus output is a flop; one access cycle
    always_comb begin
        next_prdata = '0;
        next_pready = 1'b0;
        next_pslverr = 1'b0;
        if (setup) begin
            next_pready = 1'b1;
            if (sel_hit) begin
                next_prdata = 32'(sel_q[sel_idx]);
                if (pwrite && !code_ok(int'(sel_idx), pwdata[CODE_W-1:0])) begin
                    next_pslverr = 1'b1;
                end
            end else if (paddr == OFF_MODE) begin
                next_prdata = 32'(remote_mode);
            end else if (paddr == OFF_OPMODE) begin
                next_prdata = 32'(op_mode);
            end else if (paddr == OFF_TERM && !pwrite) begin
                next_prdata = 32'(term_in);
            end else if (paddr == OFF_FUNC && !pwrite) begin
                next_prdata = 32'(fn_q);
            end else if (paddr == OFF_SPEED && !pwrite) begin
                next_prdata = 32'({speed_source, speed_index});
            end else begin
                next_pslverr = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    // each terminal lights its one function slot
    for (genvar t = 0; t < NUM_TERM; t++) begin : g_term
        logic [FN_W:0] dec;
        logic level;
        assign dec = itfr_decode(sel_q[t]);
        // overload relay reports by opening its contact
        assign level = (sel_q[t] == CODE_THERM) ? !term_in[t] : term_in[t]; // [RL5] [RL6]
        always_comb begin
            fn_hit[t] = '0;
            if (dec[FN_W]) begin
                fn_hit[t][dec[FN_W-1:0]] = level; // [RL1] [RL23]
            end
        end
    end

    always_comb begin
        logic [FN_W:0] d;
        d = '0;
        fn_or = '0;
        fn_asg = '0;
        for (int t = 0; t < NUM_TERM; t++) begin
            fn_or = fn_or | fn_hit[t]; // [RL18]
            d = itfr_decode(sel_q[t]);
            if (d[FN_W]) begin
                fn_asg[d[FN_W-1:0]] = 1'b1;
            end
        end
    end

    assign remote_on = (remote_mode != '0);
    // same three terminals carry either preset or remote meaning
    assign multi_req = fn_or[FN_FOURTH] || (!remote_on && |fn_or[FN_HIGH:FN_LOW]); // [RL21]

    itfr_speed_prio u_prio (
        .jog(fn_or[FN_JOG]),
        .multi(multi_req),
        .pid(fn_or[FN_PID]),
        .src(src_w)
    );

    always_comb begin
        next_fn = fn_or;
        next_src = src_w;
        next_index = '0;
        if (remote_on) begin
            next_fn[FN_HIGH:FN_LOW] = '0; // [RL3] [RL2]
        end
        // shutoff input stands in for an unassigned permit, and for an unassigned interlock only when op_mode is OPMODE_PANEL
        if (!fn_asg[FN_CONV]) begin
            next_fn[FN_CONV] = fn_or[FN_SHUT]; // [RL20] [RL8]
        end
        if (!fn_asg[FN_PANEL] && op_mode == OPMODE_PANEL) begin
            next_fn[FN_PANEL] = fn_or[FN_SHUT]; // [RL20] [RL9]
        end
        if (src_w == SRC_MULTI) begin
            next_index = {fn_or[FN_FOURTH], next_fn[FN_HIGH], next_fn[FN_MID], next_fn[FN_LOW]}; // [RL7]
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            fn_q <= '0;
            speed_source <= SRC_NONE;
            speed_index <= '0;
            remote_clear <= 1'b0;
            remote_decel <= 1'b0;
            remote_accel <= 1'b0;
        end else begin
            fn_q <= next_fn;
            speed_source <= next_src;
            speed_index <= next_index;
            remote_clear <= remote_on && fn_or[FN_LOW]; // [RL3]
            remote_decel <= remote_on && fn_or[FN_MID]; // [RL3]
            remote_accel <= remote_on && fn_or[FN_HIGH]; // [RL2] [RL3]
        end
    end

    assign low_speed_select = fn_q[FN_LOW];
    assign mid_speed_select = fn_q[FN_MID];
    assign high_speed_select = fn_q[FN_HIGH]; // [RL2]
    assign fourth_speed_bit = fn_q[FN_FOURTH]; // [RL7]
    assign alternate_parameter_set = fn_q[FN_ALT];
    assign current_input_select = fn_q[FN_CSEL];
    assign jog_select = fn_q[FN_JOG];
    assign power_loss_auto_restart = fn_q[FN_RESTART]; // [RL4]
    assign external_thermal_trip = fn_q[FN_THERM]; // [RL5]
    assign converter_run_permit = fn_q[FN_CONV]; // [RL8]
    assign converter_power_fail = fn_q[FN_CPF];
    assign panel_mode_interlock = fn_q[FN_PANEL]; // [RL9]
    assign dc_brake_start = fn_q[FN_DCBRK]; // [RL10]
    assign pid_enable_input = fn_q[FN_PID]; // [RL11]
    assign panel_ext_switch = fn_q[FN_PUEXT];
    // the bypass sequencer reads the same shutoff level
    assign output_shutoff = fn_q[FN_SHUT]; // [RL22]
    assign start_self_hold = fn_q[FN_HOLD];
    assign traverse_select = fn_q[FN_TRAV];
    assign forward_run_cmd = fn_q[FN_FWD]; // [RL12]
    assign reverse_run_cmd = fn_q[FN_REV]; // [RL13]
    assign drive_reset = fn_q[FN_RESET];
    assign thermistor_input = fn_q[FN_PTC]; // [RL14]
    assign pid_direction_switch = fn_q[FN_PIDDIR];
    assign panel_net_switch = fn_q[FN_PUNET];
    assign ext_net_switch = fn_q[FN_EXTNET];
    assign command_source_switch = fn_q[FN_CMDSW]; // [RL15]
    assign dc_feed_permit = fn_q[FN_DCPERM]; // [RL16]
    assign dc_feed_cancel = fn_q[FN_DCCAN]; // [RL16]
    assign pid_integral_clear = fn_q[FN_PIDCLR]; // [RL17]

    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence s_bad_fwd_write;
        psel && !penable && pwrite && paddr == 8'h08 && pwdata[CODE_W-1:0] == CODE_FWD;
    endsequence

    sequence s_access_done;
        psel && penable && pready;
    endsequence

    a_fwd_code_refused: assert property (s_bad_fwd_write ##1 s_access_done |-> // [RL12]
        pslverr ##1 (sel_q[2] == $past(sel_q[2])))
        else $error("forward code accepted on wrong terminal");

    a_fwd_routed: assert property ((sel_q[TERM_FWD] == CODE_FWD && term_in[TERM_FWD]) |=> forward_run_cmd) // [RL12]
        else $error("forward run not routed");

    a_high_routed: assert property ((sel_q[4] == CODE_HIGH && term_in[4] && !remote_on) |=> // [RL2]
        high_speed_select && !remote_accel)
        else $error("high speed select not routed");

    a_remote_swap: assert property ((sel_q[4] == CODE_HIGH && term_in[4] && remote_on) |=> // [RL3]
        remote_accel && !high_speed_select)
        else $error("remote accelerate not routed");

    a_thermal_open: assert property ((sel_q[8] == CODE_THERM && !term_in[8]) |=> external_thermal_trip) // [RL6]
        else $error("thermal trip missed on open contact");

    a_or_merge: assert property ((sel_q[8] == CODE_SHUT && sel_q[9] == CODE_SHUT && term_in[8]) // [RL18]
        |=> output_shutoff)
        else $error("duplicate assignment not ored");

    a_jog_first: assert property (jog_select |-> speed_source == SRC_JOG) // [RL19]
        else $error("jog lost priority");

    a_pid_last: assert property (speed_source == SRC_PID |-> // [RL19]
        !jog_select && !fourth_speed_bit && speed_index == '0)
        else $error("pid won over a higher source");

    a_fourth_index: assert property ((speed_source == SRC_MULTI && fourth_speed_bit) |-> speed_index[3]) // [RL7]
        else $error("fourth speed bit not in index");

    a_conv_share: assert property ((!fn_asg[FN_CONV] && fn_or[FN_SHUT]) |=> converter_run_permit) // [RL20]
        else $error("shutoff did not stand in for permit");

    a_none_silent: assert property ((sel_q[8] == CODE_NONE && term_in[8]) |-> fn_hit[8] == '0) // [RL23]
        else $error("unassigned terminal drove a function");
endmodule

// File: dv/itfr_contact_bank.sv
`timescale 1ns/1ps
// external switch contacts; 1 = contact closed, no bounce modelled
module itfr_contact_bank
    import itfr_pkg::*;
(
    input wire logic [NUM_TERM-1:0] close_cmd, // contact positions wanted
    output logic [NUM_TERM-1:0] term_in // contact state at the terminals
);
    assign term_in = close_cmd;
endmodule

// File: dv/tb_itfr_router.sv
`timescale 1ns/1ps
module tb_itfr_router
    import itfr_pkg::*;
;
    logic core_clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata;
    logic pready, pslverr;
    logic [NUM_TERM-1:0] term_in, close_cmd = '0;
    logic low_speed_select, mid_speed_select, high_speed_select, fourth_speed_bit, remote_clear, remote_decel;
    logic remote_accel, alternate_parameter_set, current_input_select, jog_select, power_loss_auto_restart;
    logic external_thermal_trip, converter_run_permit, converter_power_fail, panel_mode_interlock;
    logic dc_brake_start, pid_enable_input, panel_ext_switch, output_shutoff, start_self_hold, traverse_select;
    logic forward_run_cmd, reverse_run_cmd, drive_reset, thermistor_input, pid_direction_switch;
    logic panel_net_switch, ext_net_switch, command_source_switch, dc_feed_permit, dc_feed_cancel;
    logic pid_integral_clear;
    logic [3:0] speed_source;
    logic [SPD_W-1:0] speed_index;
    logic [28:0] fn_vec;
    int fail_count = 0;
    int checks = 0;
    always #50 core_clk = ~core_clk;
    // slot order of the function vector
    assign fn_vec = {pid_integral_clear, dc_feed_cancel, dc_feed_permit, command_source_switch, ext_net_switch,
        panel_net_switch, pid_direction_switch, thermistor_input, drive_reset, reverse_run_cmd, forward_run_cmd,
        traverse_select, start_self_hold, output_shutoff, panel_ext_switch, pid_enable_input, dc_brake_start,
        panel_mode_interlock, converter_power_fail, converter_run_permit, fourth_speed_bit, external_thermal_trip,
        power_loss_auto_restart, jog_select, current_input_select, alternate_parameter_set, high_speed_select,
        mid_speed_select, low_speed_select};
    itfr_router u_dut (.*);
    itfr_contact_bank u_sw (.close_cmd(close_cmd), .term_in(term_in));

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        // no wait-state count assumed; only the watchdog ends a hang
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr_chk(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic exp_err);
        logic [31:0] rd;
        logic e;
        apb(1'b1, a, d, rd, e);
        chk("pslverr", {31'h0, e}, {31'h0, exp_err});
    endtask
    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
        logic [31:0] rd;
        logic e;
        apb(1'b0, a, 32'h0, rd, e);
        chk("rd_err", {31'h0, e}, 32'h0);
        chk("rdata", rd, exp);
    endtask
    task automatic sel(input int k, input logic [CODE_W-1:0] code);
        wr_chk(ADDR_W'(4 * k), {18'h0, code}, 1'b0);
    endtask
    // contacts move at an edge, outputs looked at one cycle later
    task automatic drive(input logic [NUM_TERM-1:0] v);
        @(posedge core_clk);
        close_cmd <= v;
        @(posedge core_clk);
        #1;
    endtask

    task automatic t_regs();
        for (int k = 0; k < NUM_TERM; k++) rd_chk(ADDR_W'(4 * k), {18'h0, SEL_RST[k]});
        rd_chk(OFF_MODE, 32'h0);
        rd_chk(OFF_OPMODE, 32'h0);
        $display("test regs done");
    endtask
    task automatic t_codes();
        int codes[25] = '{0, 1, 2, 3, 4, 5, 6, 8, 10, 11, 12, 13, 14, 16, 24, 25, 37, 62, 64, 65, 66, 67, 70, 71, 72};
        int slots[25] = '{0, 1, 2, 3, 4, 5, 6, 8, 9, 10, 11, 12, 13, 14, 15, 16, 17, 20, 22, 23, 24, 25, 26, 27, 28};
        logic [28:0] e;
        for (int i = 0; i < 25; i++) begin
            sel(8, CODE_W'(codes[i]));
            drive(12'h100);
            e = 29'h1 << slots[i];
            if (codes[i] == 24) e[FN_CONV] = 1'b1;
            chk("fn_vec", 32'(fn_vec), 32'(e));
            drive(12'h000);
            chk("fn_idle", 32'(fn_vec), 32'h0);
        end
        sel(8, CODE_THERM);
        drive(12'h000);
        chk("thermal open", 32'(external_thermal_trip), 32'h1);
        drive(12'h100);
        chk("thermal closed", 32'(external_thermal_trip), 32'h0);
        sel(8, CODE_NONE);
        drive(12'h100);
        chk("none", 32'(fn_vec), 32'h0);
        drive(12'h003);
        chk("fwd rev", 32'(fn_vec), 32'h000C_0000);
        rd_chk(OFF_TERM, 32'h0000_0003);
        rd_chk(OFF_FUNC, 32'h000C_0000);
        rd_chk(OFF_SPEED, 32'h0000_0010);
        sel(TERM_CSEL, CODE_PTC);
        drive(NUM_TERM'(1) << TERM_CSEL);
        chk("ptc", 32'(fn_vec), 32'h0020_0000);
        sel(TERM_CSEL, SEL_RST[TERM_CSEL]);
        sel(8, SEL_RST[8]);
        $display("test codes done");
    endtask
    task automatic t_refuse();
        logic [31:0] rd;
        logic e;
        wr_chk(8'h08, 32'h9, 1'b1);
        wr_chk(8'h08, 32'h3C, 1'b1);
        wr_chk(8'h00, 32'h3D, 1'b1);
        wr_chk(8'h20, 32'h3F, 1'b1);
        wr_chk(8'h10, 32'h3F, 1'b1);
        wr_chk(OFF_TERM, 32'h0, 1'b1);
        wr_chk(8'h80, 32'h0, 1'b1);
        apb(1'b0, 8'h80, 32'h0, rd, e);
        chk("unmapped", {31'h0, e}, 32'h1);
        rd_chk(8'h08, {18'h0, SEL_RST[2]});
        rd_chk(8'h20, {18'h0, SEL_RST[8]});
        $display("test refuse done");
    endtask
    task automatic t_dup_remote();
        sel(8, 14'h000D);
        sel(10, 14'h000D);
        drive(12'h100);
        chk("or a", 32'(dc_brake_start), 32'h1);
        drive(12'h400);
        chk("or b", 32'(dc_brake_start), 32'h1);
        sel(8, SEL_RST[8]);
        sel(10, SEL_RST[10]);
        wr_chk(OFF_MODE, 32'h1, 1'b0);
        drive(12'h004);
        chk("rem clr", 32'({remote_clear, remote_decel, remote_accel, low_speed_select}), 32'h8);
        drive(12'h008);
        chk("rem dec", 32'({remote_clear, remote_decel, remote_accel, mid_speed_select}), 32'h4);
        drive(12'h010);
        chk("rem acc", 32'({remote_clear, remote_decel, remote_accel, high_speed_select}), 32'h2);
        wr_chk(OFF_MODE, 32'h0, 1'b0);
        drive(12'h010);
        chk("high", 32'({remote_accel, high_speed_select}), 32'h1);
        $display("test dup remote done");
    endtask
    task automatic t_prio();
        logic [11:0] pat[6] = '{12'h400, 12'h404, 12'h514, 12'h100, 12'h594, 12'h000};
        logic [7:0] exp[6] = '{8'h80, 8'h41, 8'h4D, 8'h48, 8'h20, 8'h10};
        sel(8, 14'h0008);
        sel(10, 14'h000E);
        for (int i = 0; i < 6; i++) begin
            drive(pat[i]);
            chk("src idx", 32'({speed_source, speed_index}), 32'(exp[i]));
        end
        sel(8, SEL_RST[8]);
        sel(10, SEL_RST[10]);
        $display("test prio done");
    endtask
    task automatic t_subst();
        drive(12'h200);
        chk("conv", 32'({converter_run_permit, panel_mode_interlock, output_shutoff}), 32'h5);
        wr_chk(OFF_OPMODE, 32'(OPMODE_PANEL), 1'b0);
        drive(12'h200);
        chk("panel", 32'({converter_run_permit, panel_mode_interlock, output_shutoff}), 32'h7);
        sel(8, 14'h000C);
        drive(12'h200);
        chk("panel own", 32'({converter_run_permit, panel_mode_interlock, output_shutoff}), 32'h5);
        sel(8, 14'h000A);
        drive(12'h100);
        chk("conv own", 32'({converter_run_permit, panel_mode_interlock, output_shutoff}), 32'h4);
        sel(8, SEL_RST[8]);
        wr_chk(OFF_OPMODE, 32'h0, 1'b0);
        $display("test subst done");
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        #(20000 * 100);
        fail_count++;
        final_report();
    end
    initial begin
        repeat (5) @(posedge core_clk);
        chk("rst src", 32'(speed_source), 32'h1);
        repeat (5) @(posedge core_clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        t_regs();
        t_codes();
        t_refuse();
        t_dup_remote();
        t_prio();
        t_subst();
        final_report();
    end
endmodule
